// file: design/isc_regs.sv
// Purpose: status and command registers of a 32-source vectored interrupt controller
// Assumes: single 50 MHz clock, Avalon-MM master with waitrequest, source events arrive as set pulses
// Notes:   arbitration, source modes and end-of-interrupt handling live outside this block
`timescale 1ns/10ps
module isc_regs (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire isc_pkg::isc_av_req_s      av_req_in,
  output isc_pkg::isc_av_rsp_s           av_rsp_out,
  input  wire logic [31:0]               source_set_in,
  input  wire logic [4:0]                current_source_number_in,
  output logic                           fast_request_out_n,
  output logic                           normal_request_out_n,
  output logic [31:0]                    enable_mask_out,
  output logic [31:0]                    pending_out,
  output logic                           irq_out
);
  import isc_pkg::*;

  isc_bus_state_e  bus_state;
  isc_bus_state_e  next_bus_state;
  logic [31:0]     pending;
  logic [31:0]     enable_mask;
  logic [31:0]     src_vec0;
  logic [31:0]     spurious_vector_store;
  logic            fast_line_state;
  logic            normal_line_state;
  logic [2:0]      ev_status;
  logic [2:0]      ev_enable;
  logic [31:0]     readdata;
  logic            irq;

  // byte lanes and request qualification
  wire logic [31:0] be_mask   = {{8{av_req_in.byteenable[3]}}, {8{av_req_in.byteenable[2]}},
                                 {8{av_req_in.byteenable[1]}}, {8{av_req_in.byteenable[0]}}};
  wire logic [31:0] wdata_be  = av_req_in.writedata & be_mask;
  wire logic        wr_take   = av_req_in.write & ~av_req_in.read;
  wire logic        rd_take   = av_req_in.read & ~av_req_in.write & (bus_state == ISC_BUS_IDLE);
  wire logic        waitreq   = av_req_in.read & (bus_state == ISC_BUS_IDLE);

  // address decode
  wire logic hit_vec0   = (av_req_in.address == ISC_SRC_VEC0_ADDR);
  wire logic hit_fast   = (av_req_in.address == ISC_FAST_VEC_ADDR);
  wire logic hit_id     = (av_req_in.address == ISC_SRC_ID_ADDR);
  wire logic hit_pend   = (av_req_in.address == ISC_PENDING_ADDR);
  wire logic hit_mask   = (av_req_in.address == ISC_MASK_ADDR);
  wire logic hit_core   = (av_req_in.address == ISC_CORE_LINE_ADDR);
  wire logic hit_enable = (av_req_in.address == ISC_ENABLE_ADDR);
  wire logic hit_dis    = (av_req_in.address == ISC_DISABLE_ADDR);
  wire logic hit_clear  = (av_req_in.address == ISC_CLEAR_ADDR);
  wire logic hit_set    = (av_req_in.address == ISC_SET_ADDR);
  wire logic hit_spu    = (av_req_in.address == ISC_SPURIOUS_ADDR);
  wire logic hit_evst   = (av_req_in.address == ISC_EV_STATUS_ADDR);
  wire logic hit_evclr  = (av_req_in.address == ISC_EV_CLEAR_ADDR);
  wire logic hit_even   = (av_req_in.address == ISC_EV_ENABLE_ADDR);

  // write-one command vectors; zero bits and unselected lanes do nothing
  wire logic [31:0] cmd_enable  = (wr_take & hit_enable) ? wdata_be : ISC_RESET_WORD;
  wire logic [31:0] cmd_disable = (wr_take & hit_dis)    ? wdata_be : ISC_RESET_WORD;
  wire logic [31:0] cmd_clear   = (wr_take & hit_clear)  ? wdata_be : ISC_RESET_WORD;
  wire logic [31:0] cmd_set     = (wr_take & hit_set)    ? wdata_be : ISC_RESET_WORD;
  wire logic [2:0]  cmd_ev_clr  = (wr_take & hit_evclr)  ? wdata_be[2:0] : ISC_EV_RESET;

  // enable and disable live at different addresses, so they never meet in one cycle
  wire logic [31:0] next_enable_mask = (enable_mask | cmd_enable) & ~cmd_disable;
  // a source event in the cycle of a clear keeps the bit set
  wire logic [31:0] next_pending     = (pending & ~cmd_clear) | cmd_set | source_set_in;

  wire logic [31:0] next_src_vec0 = (wr_take & hit_vec0) ? ((src_vec0 & ~be_mask) | wdata_be) : src_vec0;
  wire logic [31:0] next_spurious = (wr_take & hit_spu) ?
                                    ((spurious_vector_store & ~be_mask) | wdata_be) : spurious_vector_store;
  wire logic [2:0]  next_ev_enable = (wr_take & hit_even) ?
                                     ((ev_enable & ~be_mask[2:0]) | wdata_be[2:0]) : ev_enable;

  // request lines follow enabled pending sources one cycle later
  wire logic next_fast_line   = pending[ISC_FAST_SRC_BIT] & enable_mask[ISC_FAST_SRC_BIT];
  wire logic next_normal_line = |(pending[31:1] & enable_mask[31:1]);

  // fast vector answer: source 0 handler while the fast line is up, else the spurious handler
  wire logic [31:0] fast_vector_value = fast_line_state ? src_vec0 : spurious_vector_store;
  wire logic [31:0] core_line_word    = {30'h00000000, normal_line_state, fast_line_state};
  wire logic [31:0] src_id_word       = {27'h0000000, current_source_number_in};

  // read selection; unmapped and write-only addresses read as zero
  wire logic [31:0] rd_word =
    hit_vec0 ? src_vec0 :
    hit_fast ? fast_vector_value :
    hit_id   ? src_id_word :
    hit_pend ? pending :
    hit_mask ? enable_mask :
    hit_core ? core_line_word :
    hit_spu  ? spurious_vector_store :
    hit_evst ? {29'h00000000, ev_status} :
    hit_even ? {29'h00000000, ev_enable} :
    ISC_RESET_WORD;

  // events for the local interrupt: line rises and a spurious fast vector fetch
  wire logic [2:0] ev_raise = {rd_take & hit_fast & ~fast_line_state,
                               next_normal_line & ~normal_line_state,
                               next_fast_line & ~fast_line_state};
  wire logic [2:0] next_ev_status = (ev_status & ~cmd_ev_clr) | ev_raise;

  // a read always costs one wait cycle so that read data comes from a flop
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      ISC_BUS_IDLE: begin
        if (rd_take) begin
          next_bus_state = ISC_BUS_ANSWER;
        end
      end
      ISC_BUS_ANSWER: begin
        next_bus_state = ISC_BUS_IDLE;
      end
      default: begin
        next_bus_state = ISC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state <= ISC_BUS_IDLE;
      readdata  <= ISC_RESET_WORD;
    end else begin
      bus_state <= next_bus_state;
      if (rd_take) begin
        readdata <= rd_word;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending               <= ISC_RESET_WORD;
      enable_mask           <= ISC_RESET_WORD;
      src_vec0              <= ISC_RESET_WORD;
      spurious_vector_store <= ISC_RESET_WORD;
    end else begin
      pending               <= next_pending;
      enable_mask           <= next_enable_mask;
      src_vec0              <= next_src_vec0;
      spurious_vector_store <= next_spurious;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_line_state   <= 1'b0;
      normal_line_state <= 1'b0;
      ev_status         <= ISC_EV_RESET;
      ev_enable         <= ISC_EV_RESET;
      irq               <= 1'b0;
    end else begin
      fast_line_state   <= next_fast_line;
      normal_line_state <= next_normal_line;
      ev_status         <= next_ev_status;
      ev_enable         <= next_ev_enable;
      irq               <= |(ev_status & ev_enable);
    end
  end

  assign av_rsp_out.readdata    = readdata;
  assign av_rsp_out.waitrequest = waitreq;
  assign fast_request_out_n     = ~fast_line_state;
  assign normal_request_out_n   = ~normal_line_state;
  assign enable_mask_out        = enable_mask;
  assign pending_out            = pending;
  assign irq_out                = irq;

  property p_fast_vec;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_fast && fast_line_state) |=> (!av_rsp_out.waitrequest && av_rsp_out.readdata == $past(src_vec0));
  endproperty
  a_fast_vec: assert property (p_fast_vec) else $error("fast vector read did not return source 0 vector");

  property p_spurious;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_fast && !fast_line_state) |=> (av_rsp_out.readdata == $past(spurious_vector_store));
  endproperty
  a_spurious: assert property (p_spurious) else $error("idle fast vector read did not return spurious vector");

  property p_src_id;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_id) |=> (av_rsp_out.readdata == {27'h0000000, $past(current_source_number_in)});
  endproperty
  a_src_id: assert property (p_src_id) else $error("source identifier read mismatch");

  property p_pend_read;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_pend) |=> (av_rsp_out.readdata == $past(pending_out));
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending read does not show pending vector");

  property p_pend_src;
    @(posedge ref_clk_in) disable iff (rst_in)
    (|source_set_in) |=> ((pending_out & $past(source_set_in)) == $past(source_set_in));
  endproperty
  a_pend_src: assert property (p_pend_src) else $error("source event not shown as pending");

  property p_mask_read;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_mask) |=> (av_rsp_out.readdata == $past(enable_mask_out));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read does not show enable mask");

  property p_fast_line;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_core) |=> (av_rsp_out.readdata[0] == !$past(fast_request_out_n));
  endproperty
  a_fast_line: assert property (p_fast_line) else $error("core line bit 0 disagrees with fast line");

  property p_normal_line;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_core) |=> (av_rsp_out.readdata[1] == !$past(normal_request_out_n));
  endproperty
  a_normal_line: assert property (p_normal_line) else $error("core line bit 1 disagrees with normal line");

  property p_enable_cmd;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_enable) |=> (((enable_mask_out & $past(wdata_be)) == $past(wdata_be)) &&
                                 ((enable_mask_out & ~$past(wdata_be)) == ($past(enable_mask_out) & ~$past(wdata_be))));
  endproperty
  a_enable_cmd: assert property (p_enable_cmd) else $error("enable command misapplied");

  property p_disable_cmd;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_dis) |=> (((enable_mask_out & $past(wdata_be)) == 32'h00000000) &&
                              ((enable_mask_out & ~$past(wdata_be)) == ($past(enable_mask_out) & ~$past(wdata_be))));
  endproperty
  a_disable_cmd: assert property (p_disable_cmd) else $error("disable command misapplied");

  property p_clear_cmd;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_clear) |=> ((pending_out & $past(wdata_be & ~source_set_in)) == 32'h00000000);
  endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear command left a bit pending");

  property p_set_cmd;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_set) |=> (((pending_out & $past(wdata_be)) == $past(wdata_be)) &&
                              ((pending_out & ~$past(wdata_be)) == (($past(pending_out) | $past(source_set_in)) & ~$past(wdata_be))));
  endproperty
  a_set_cmd: assert property (p_set_cmd) else $error("set command misapplied");

  property p_mask_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(wr_take && (hit_enable || hit_dis)) |=> $stable(enable_mask_out);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without a command");

  property p_line_follow;
    @(posedge ref_clk_in) disable iff (rst_in)
    (pending_out[0] && enable_mask_out[0]) |=> !fast_request_out_n;
  endproperty
  a_line_follow: assert property (p_line_follow) else $error("fast line not asserted for enabled fast source");

  // bus handshake: writes never wait, reads wait exactly one cycle
  property p_write_nowait;
    @(posedge ref_clk_in) disable iff (rst_in)
    (av_req_in.write && !av_req_in.read) |-> !av_rsp_out.waitrequest;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write was held off");

  property p_read_wait;
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_take |=> !av_rsp_out.waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer not given after one wait cycle");

  property p_readdata_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !rd_take |=> $stable(av_rsp_out.readdata);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold) else $error("read data changed without a read");

  // a request with both directions set must not touch the mask
  property p_rw_refused;
    @(posedge ref_clk_in) disable iff (rst_in)
    (av_req_in.read && av_req_in.write) |=> $stable(enable_mask_out);
  endproperty
  a_rw_refused: assert property (p_rw_refused) else $error("mask changed on a read and write request");

  property p_fast_drop;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(pending_out[0] && enable_mask_out[0]) |=> fast_request_out_n;
  endproperty
  a_fast_drop: assert property (p_fast_drop) else $error("fast line asserted without enabled fast source");

  property p_normal_follow;
    @(posedge ref_clk_in) disable iff (rst_in)
    (|(pending_out[31:1] & enable_mask_out[31:1])) |=> !normal_request_out_n;
  endproperty
  a_normal_follow: assert property (p_normal_follow) else $error("normal line not asserted for enabled source");

  property p_normal_drop;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(|(pending_out[31:1] & enable_mask_out[31:1])) |=> normal_request_out_n;
  endproperty
  a_normal_drop: assert property (p_normal_drop) else $error("normal line asserted with nothing enabled");

  property p_pend_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    (!(wr_take && (hit_clear || hit_set)) && !(|source_set_in)) |=> $stable(pending_out);
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending changed without a cause");

  property p_clear_keep;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_clear) |=>
      ((pending_out & ~$past(wdata_be)) == (($past(pending_out) | $past(source_set_in)) & ~$past(wdata_be)));
  endproperty
  a_clear_keep: assert property (p_clear_keep) else $error("clear command touched a bit written zero");

  // a source event racing a clear must survive it
  property p_clear_set_wins;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_clear) |=> ((pending_out & $past(source_set_in)) == $past(source_set_in));
  endproperty
  a_clear_set_wins: assert property (p_clear_set_wins) else $error("clear swallowed a new source event");

  property p_core_upper;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_core) |=> (av_rsp_out.readdata[31:2] == 30'h00000000);
  endproperty
  a_core_upper: assert property (p_core_upper) else $error("core line upper bits not zero");

  property p_src_id_upper;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && hit_id) |=> (av_rsp_out.readdata[31:5] == 27'h0000000);
  endproperty
  a_src_id_upper: assert property (p_src_id_upper) else $error("source identifier upper bits not zero");

  property p_wo_read_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_take && (hit_enable || hit_dis || hit_clear || hit_set)) |=> (av_rsp_out.readdata == 32'h00000000);
  endproperty
  a_wo_read_zero: assert property (p_wo_read_zero) else $error("write-only command register read not zero");

  property p_vec0_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_vec0 && (av_req_in.byteenable == 4'hf)) |=> (src_vec0 == $past(av_req_in.writedata));
  endproperty
  a_vec0_write: assert property (p_vec0_write) else $error("source 0 vector write not stored");

  property p_spu_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_take && hit_spu && (av_req_in.byteenable == 4'hf)) |=> (spurious_vector_store == $past(av_req_in.writedata));
  endproperty
  a_spu_write: assert property (p_spu_write) else $error("spurious vector write not stored");

  property p_irq_level;
    @(posedge ref_clk_in) disable iff (rst_in)
    (|(ev_status & ev_enable)) |=> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised for enabled event");

  property p_ev_set_wins;
    @(posedge ref_clk_in) disable iff (rst_in)
    ev_raise[0] |=> ev_status[0];
  endproperty
  a_ev_set_wins: assert property (p_ev_set_wins) else $error("fast rise event lost");
endmodule

// file: inc/isc_pkg.sv
// Purpose: shared constants and carriers for the interrupt status and command register slice
// Assumes: 32-bit Avalon-MM slave, byte addresses, one aligned word per register
// Notes:   all registers clear to zero at reset
package isc_pkg;
  localparam int unsigned ISC_DATA_W = 32;
  localparam int unsigned ISC_SRC_ID_W = 5;

  localparam logic [31:0] ISC_SRC_VEC0_ADDR   = 32'hfffff080;
  localparam logic [31:0] ISC_FAST_VEC_ADDR   = 32'hfffff104;
  localparam logic [31:0] ISC_SRC_ID_ADDR     = 32'hfffff108;
  localparam logic [31:0] ISC_PENDING_ADDR    = 32'hfffff10c;
  localparam logic [31:0] ISC_MASK_ADDR       = 32'hfffff110;
  localparam logic [31:0] ISC_CORE_LINE_ADDR  = 32'hfffff114;
  localparam logic [31:0] ISC_ENABLE_ADDR     = 32'hfffff120;
  localparam logic [31:0] ISC_DISABLE_ADDR    = 32'hfffff124;
  localparam logic [31:0] ISC_CLEAR_ADDR      = 32'hfffff128;
  localparam logic [31:0] ISC_SET_ADDR        = 32'hfffff12c;
  localparam logic [31:0] ISC_SPURIOUS_ADDR   = 32'hfffff134;
  localparam logic [31:0] ISC_EV_STATUS_ADDR  = 32'hfffff150;
  localparam logic [31:0] ISC_EV_CLEAR_ADDR   = 32'hfffff154;
  localparam logic [31:0] ISC_EV_ENABLE_ADDR  = 32'hfffff158;

  localparam logic [31:0] ISC_RESET_WORD = 32'h00000000;
  localparam logic [2:0]  ISC_EV_RESET   = 3'h0;

  localparam int unsigned ISC_FAST_SRC_BIT    = 0;
  localparam int unsigned ISC_SYS_SRC_BIT     = 1;
  localparam int unsigned ISC_FAST_LINE_BIT   = 0;
  localparam int unsigned ISC_NORMAL_LINE_BIT = 1;

  localparam int unsigned ISC_EV_W           = 3;
  localparam int unsigned ISC_EV_FAST_RISE   = 0;
  localparam int unsigned ISC_EV_NORMAL_RISE = 1;
  localparam int unsigned ISC_EV_SPURIOUS    = 2;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } isc_av_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } isc_av_rsp_s;

  typedef enum logic [1:0] {
    ISC_BUS_IDLE   = 2'b00,
    ISC_BUS_ANSWER = 2'b01
  } isc_bus_state_e;
endpackage

// file: testbench/isc_src_model.sv
// Purpose: source-side partner that raises per-source set pulses and reports the serviced source number
// Assumes: bench asks for pulses right after a rising edge
// Notes:   pulses are registered so they never change on the sampling edge of the block
`timescale 1ns/10ps
module isc_src_model (
  input  wire logic        ref_clk_in,
  input  wire logic [31:0] fire_in,
  input  wire logic [4:0]  serving_in,
  output logic      [31:0] source_set_out,
  output logic      [4:0]  current_source_number_out
);
  always_ff @(posedge ref_clk_in) begin
    source_set_out <= fire_in;
  end
  assign current_source_number_out = serving_in;
endmodule

// file: testbench/tb_isc_regs.sv
// Purpose: self-checking bench for the interrupt status and command register slice
// Assumes: one read wait cycle, zero-wait writes, all lanes enabled
// Notes:   bus master samples waitrequest and read data at each rising edge
`timescale 1ns/10ps
module tb_isc_regs;
  import isc_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  isc_av_req_s req        = '0;
  isc_av_rsp_s rsp;
  logic [31:0] fire       = '0;
  logic [31:0] src_set, mask, pend, rd;
  logic [4:0]  serving    = '0;
  logic [4:0]  src_num;
  logic        fq_n, nq_n, irq;
  int          n_mismatch = 0;
  int          tests_run  = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  isc_regs u_dut (
    .ref_clk_in               (ref_clk_in),
    .rst_in                   (rst_in),
    .av_req_in                (req),
    .av_rsp_out               (rsp),
    .source_set_in            (src_set),
    .current_source_number_in (src_num),
    .fast_request_out_n       (fq_n),
    .normal_request_out_n     (nq_n),
    .enable_mask_out          (mask),
    .pending_out              (pend),
    .irq_out                  (irq)
  );

  isc_src_model u_src (
    .ref_clk_in                (ref_clk_in),
    .fire_in                   (fire),
    .serving_in                (serving),
    .source_set_out            (src_set),
    .current_source_number_out (src_num)
  );

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compares g as passed in; callers other than irq_off first run edge_wait so the registered outputs have landed
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; one idle edge before the next request
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int   n;
    logic w;
    n = 0;
    req.read       <= ~wr;
    req.write      <= wr;
    req.address    <= a;
    req.writedata  <= d;
    req.byteenable <= 4'hf;
    // values read right after the edge are those the slave showed at that edge
    do begin
      @(posedge ref_clk_in);
      n++;
      w = rsp.waitrequest;
      q = rsp.readdata;
    end while (w !== 1'b0 && n < 50);
    if (w !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, e, rd);
  endtask

  task automatic edge_wait(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rc("pending", ISC_PENDING_ADDR, 32'h0);
    rc("mask", ISC_MASK_ADDR, 32'h0);
    rc("core_line", ISC_CORE_LINE_ADDR, 32'h0);
    wr(ISC_SRC_VEC0_ADDR, 32'h12345678);
    wr(ISC_SPURIOUS_ADDR, 32'hcafe0000);
    rc("fast_vec_idle", ISC_FAST_VEC_ADDR, 32'hcafe0000);
    wr(ISC_SET_ADDR, 32'h00000001);
    rc("fast_vec_masked", ISC_FAST_VEC_ADDR, 32'hcafe0000);
    rc("pending", ISC_PENDING_ADDR, 32'h1);
    wr(ISC_ENABLE_ADDR, 32'h80000005);
    rc("mask", ISC_MASK_ADDR, 32'h80000005);
    wr(ISC_ENABLE_ADDR, 32'h00000002);
    rc("mask", ISC_MASK_ADDR, 32'h80000007);
    wr(ISC_DISABLE_ADDR, 32'h80000004);
    rc("mask", ISC_MASK_ADDR, 32'h00000003);
    chk("mask_port", 32'h3, mask);
    rc("core_line", ISC_CORE_LINE_ADDR, 32'h1);
    rc("fast_vec", ISC_FAST_VEC_ADDR, 32'h12345678);
    fire <= 32'h2;
    @(posedge ref_clk_in);
    fire <= 32'h0;
    repeat (3) @(posedge ref_clk_in);
    rc("pending", ISC_PENDING_ADDR, 32'h3);
    chk("pending_port", 32'h3, pend);
    rc("core_line", ISC_CORE_LINE_ADDR, 32'h3);
    edge_wait(0);
    chk_bit("normal_n", 1'b0, nq_n);
    chk_bit("fast_n", 1'b0, fq_n);
    wr(ISC_CLEAR_ADDR, 32'h00000001);
    rc("pending", ISC_PENDING_ADDR, 32'h2);
    rc("core_line", ISC_CORE_LINE_ADDR, 32'h2);
    rc("fast_vec_cleared", ISC_FAST_VEC_ADDR, 32'hcafe0000);
    serving <= 5'h1b;
    @(posedge ref_clk_in);
    rc("src_id", ISC_SRC_ID_ADDR, 32'h1b);
    rc("cmd_read", ISC_ENABLE_ADDR, 32'h0);
    rc("unmapped", 32'hfffff200, 32'h0);
    // fast rise, normal rise and spurious reads have all happened by now
    rc("ev_status", ISC_EV_STATUS_ADDR, 32'h7);
    chk_bit("irq_off", 1'b0, irq);
    wr(ISC_EV_ENABLE_ADDR, 32'h2);
    edge_wait(1);
    chk_bit("irq_on", 1'b1, irq);
    wr(ISC_EV_CLEAR_ADDR, 32'h2);
    edge_wait(1);
    chk_bit("irq_cleared", 1'b0, irq);
    rc("ev_status", ISC_EV_STATUS_ADDR, 32'h5);
    wr(ISC_EV_ENABLE_ADDR, 32'h1);
    edge_wait(1);
    chk_bit("irq_fast", 1'b1, irq);
    wr(ISC_EV_ENABLE_ADDR, 32'h0);
    edge_wait(1);
    chk_bit("irq_masked", 1'b0, irq);
    wr(ISC_EV_CLEAR_ADDR, 32'h7);
    rc("ev_status", ISC_EV_STATUS_ADDR, 32'h0);
    conclude();
  end
endmodule
